// ===== hw/liu_pin_pkg.sv
package liu_pin_pkg;
  localparam int num_channels = 8;
  localparam int addr_width = 5;
  localparam int monitor_width = 4;
  localparam int apb_addr_width = 8;
  // register byte offsets
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] rxclk_inv_offset = 8'h04;
  localparam logic [7:0] status_offset = 8'h08;
  localparam logic [7:0] host_addr_offset = 8'h0C;
  // ctrl fields
  localparam int ctrl_term_off_bit = 0;
  localparam int ctrl_hw_mode_bit = 1;
  localparam int ctrl_host_mode_lsb = 2;
  // status fields
  localparam int stat_oe_bit = 0;
  localparam int stat_edge_bit = 1;
  localparam int stat_ext_term_bit = 2;
  localparam int stat_mon_lsb = 4;
  localparam int stat_term_off_bit = 8;
  localparam logic [31:0] ctrl_reset = 32'h0000_0002;
  localparam logic [7:0] rxclk_inv_reset = 8'h00;
  // host modes
  localparam logic [1:0] host_parallel = 2'h0;
  localparam logic [1:0] host_serial = 2'h1;
  localparam logic [1:0] host_mux = 2'h2;
  // monitor select codes
  localparam logic [3:0] mon_none = 4'h0;
  localparam logic [3:0] mon_rx_first = 4'h1;
  localparam logic [3:0] mon_rx_last = 4'h7;
  localparam logic [3:0] mon_tx_first = 4'h9;
  localparam logic [3:0] mon_tx_last = 4'hF;
endpackage

// ===== hw/liu_monitor_decode.sv
`timescale 1ns/100ps
`default_nettype none
module liu_monitor_decode
  import liu_pin_pkg::*;
(
  input wire logic [3:0] select_in,
  output logic [7:0] rx_route_out,
  output logic [7:0] tx_route_out
);
  always_comb begin
    rx_route_out = 8'h00;
    tx_route_out = 8'h00;
    // rx of channel code, tx of channel code-8
    if (select_in >= mon_rx_first && select_in <= mon_rx_last) begin
      rx_route_out[select_in[2:0]] = 1'b1;
    end else if (select_in >= mon_tx_first && select_in <= mon_tx_last) begin
      tx_route_out[select_in[2:0]] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== hw/liu_global_pin_control.sv
`timescale 1ns/100ps
`default_nettype none
module liu_global_pin_control
  import liu_pin_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pins
  input wire logic [4:0] addr_pins_in,
  input wire logic output_enable_in,
  input wire logic edge_polarity_select_in,
  // host serial output request
  input wire logic serial_host_out_data_in,
  // line control
  output logic [7:0] tx_line_tip_oe_out,
  output logic [7:0] tx_line_ring_oe_out,
  output logic [7:0] rx_line_tip_term_en_out,
  output logic rx_external_term_out,
  output logic [7:0] monitor_rx_route_out,
  output logic [7:0] monitor_tx_route_out,
  output logic [7:0] rxclk_invert_out,
  output logic serial_out_falling_edge_out,
  output logic serial_host_out_data_out,
  output logic [4:0] host_reg_addr_out
);
  logic [31:0] ctrl, next_ctrl;
  logic [7:0] rxclk_inv, next_rxclk_inv;
  logic [31:0] prdata, next_prdata;
  logic pready, next_pready, pslverr, next_pslverr;
  logic [7:0] tip_oe, term_en, inv;
  logic ext_term, next_ext_term;
  logic [7:0] mon_rx, next_mon_rx, mon_tx, next_mon_tx;
  logic fall_edge, next_fall_edge, serial_host_out, next_sdo;
  logic [4:0] host_addr, next_host_addr;
  logic [7:0] dec_rx, dec_tx;
  logic hw_mode;
  logic [1:0] host_mode;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic read_hit;
  logic setup_phase;
  logic write_commit;

  assign hw_mode = ctrl[ctrl_hw_mode_bit];
  assign host_mode = ctrl[ctrl_host_mode_lsb +: 2];
  assign setup_phase = psel_in && !penable_in;
  // write lands on the edge where the master sees pready high
  assign write_commit = psel_in && penable_in && pready && pwrite_in;

  liu_monitor_decode u_decode (
    .select_in(addr_pins_in[3:0]),
    .rx_route_out(dec_rx),
    .tx_route_out(dec_tx)
  );

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[stat_oe_bit] = output_enable_in;
    status_word[stat_edge_bit] = edge_polarity_select_in;
    status_word[stat_ext_term_bit] = ext_term;
    status_word[stat_mon_lsb +: monitor_width] = addr_pins_in[3:0];
    status_word[stat_term_off_bit] = ~term_en[0];
  end

  // read mux, unmapped offsets read as zero
  always_comb begin
    read_word = 32'h0000_0000;
    read_hit = 1'b1;
    unique case (paddr_in)
      ctrl_offset: read_word = ctrl;
      rxclk_inv_offset: read_word = {24'h00_0000, rxclk_inv};
      status_offset: read_word = status_word;
      host_addr_offset: read_word = {27'h000_0000, host_addr};
      default: read_hit = 1'b0;
    endcase
  end

  // apb slave, answers in the first access cycle
  always_comb begin
    next_ctrl = ctrl;
    next_rxclk_inv = rxclk_inv;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (setup_phase) begin
      next_pready = 1'b1;
      next_prdata = read_word;
      next_pslverr = !read_hit;
    end
    if (write_commit) begin
      if (paddr_in == ctrl_offset) begin
        next_ctrl = pwdata_in & 32'h0000_000F;
      end else if (paddr_in == rxclk_inv_offset) begin
        next_rxclk_inv = pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl <= ctrl_reset;
      rxclk_inv <= rxclk_inv_reset;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      rxclk_inv <= next_rxclk_inv;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // host address latch, other host modes ignore the grounded pins
  always_comb begin
    next_host_addr = host_addr;
    if (!hw_mode && host_mode == host_parallel) begin
      next_host_addr = addr_pins_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      host_addr <= 5'h00;
    end else begin
      host_addr <= next_host_addr;
    end
  end

  // hardware mode pins, termination choice held when software owns setup
  always_comb begin
    next_ext_term = ext_term;
    next_mon_rx = 8'h00;
    next_mon_tx = 8'h00;
    if (hw_mode) begin
      next_ext_term = addr_pins_in[4];
      next_mon_rx = dec_rx;
      next_mon_tx = dec_tx;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_term <= 1'b0;
      mon_rx <= 8'h00;
      mon_tx <= 8'h00;
    end else begin
      ext_term <= next_ext_term;
      mon_rx <= next_mon_rx;
      mon_tx <= next_mon_tx;
    end
  end

  // serial host output edge and data
  always_comb begin
    next_fall_edge = edge_polarity_select_in;
    next_sdo = serial_host_out_data_in;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fall_edge <= 1'b0;
      serial_host_out <= 1'b0;
    end else begin
      fall_edge <= next_fall_edge;
      serial_host_out <= next_sdo;
    end
  end

  // per-channel drive, termination and clock inversion
  for (genvar ch = 0; ch < num_channels; ch++) begin : g_channel
    logic drive, next_drive, term, next_term, invert, next_invert;

    always_comb begin
      next_drive = output_enable_in;
      // internal termination off in external mode, or for a low enable when armed
      next_term = !next_ext_term;
      if (!output_enable_in && ctrl[ctrl_term_off_bit]) begin
        next_term = 1'b0;
      end
      next_invert = rxclk_inv[ch];
      if (edge_polarity_select_in) begin
        next_invert = 1'b1;
      end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        drive <= 1'b0;
        term <= 1'b1;
        invert <= 1'b0;
      end else begin
        drive <= next_drive;
        term <= next_term;
        invert <= next_invert;
      end
    end

    assign tip_oe[ch] = drive;
    assign term_en[ch] = term;
    assign inv[ch] = invert;
  end

  assign prdata_out = prdata;
  assign pready_out = pready;
  assign pslverr_out = pslverr;
  assign tx_line_tip_oe_out = tip_oe;
  assign tx_line_ring_oe_out = tip_oe;
  assign rx_line_tip_term_en_out = term_en;
  assign rx_external_term_out = ext_term;
  assign monitor_rx_route_out = mon_rx;
  assign monitor_tx_route_out = mon_tx;
  assign rxclk_invert_out = inv;
  assign serial_out_falling_edge_out = fall_edge;
  assign serial_host_out_data_out = serial_host_out;
  assign host_reg_addr_out = host_addr;
endmodule
`default_nettype wire

// ===== verification/liu_pin_sva.sv
`timescale 1ns/100ps
`default_nettype none
module liu_pin_sva
  import liu_pin_pkg::*;
(
  input wire logic core_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out,
  input wire logic output_enable_in, edge_polarity_select_in, rx_external_term_out,
  input wire logic serial_out_falling_edge_out,
  input wire logic [4:0] addr_pins_in, host_reg_addr_out,
  input wire logic [7:0] paddr_in, tx_line_tip_oe_out, tx_line_ring_oe_out, rxclk_invert_out,
  input wire logic [7:0] rx_line_tip_term_en_out, monitor_rx_route_out, monitor_tx_route_out,
  input wire logic [31:0] pwdata_in
);
  logic [3:0] ctrl;
  logic [7:0] inv_reg;
  wire logic wr = psel_in && penable_in && pready_out && pwrite_in;
  // shadow of the writable registers, updated where the master sees pready
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl <= ctrl_reset[3:0];
      inv_reg <= rxclk_inv_reset;
    end else if (wr && paddr_in == ctrl_offset) begin
      ctrl <= pwdata_in[3:0];
    end else if (wr && paddr_in == rxclk_inv_offset) begin
      inv_reg <= pwdata_in[7:0];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_TIP: assert property (!output_enable_in |=> tx_line_tip_oe_out == 8'h00)
    else $error("tip");
  AST_RING: assert property (!output_enable_in |=> tx_line_ring_oe_out == 8'h00)
    else $error("ring");
  AST_TERM: assert property (ctrl[ctrl_term_off_bit] && !output_enable_in
    |=> rx_line_tip_term_en_out == 8'h00) else $error("term");
  AST_EXT: assert property (ctrl[1] && addr_pins_in[4] |=> rx_external_term_out)
    else $error("ext");
  AST_MRX: assert property (ctrl[1] && addr_pins_in[3:0] inside {[1:7]}
    |=> monitor_rx_route_out == 8'h01 << ($past(addr_pins_in) & 5'h07)) else $error("mrx");
  AST_MTX: assert property (ctrl[1] && addr_pins_in[3:0] inside {[9:15]}
    |=> monitor_tx_route_out == 8'h01 << ($past(addr_pins_in) & 5'h07)) else $error("mtx");
  AST_INV: assert property (edge_polarity_select_in |=> rxclk_invert_out == 8'hFF)
    else $error("inv");
  AST_EDGE: assert property (edge_polarity_select_in |=> serial_out_falling_edge_out)
    else $error("edge");
  AST_RISE: assert property (!edge_polarity_select_in |=> !serial_out_falling_edge_out)
    else $error("rise");
  AST_PERCH: assert property (!edge_polarity_select_in
    |=> rxclk_invert_out == $past(inv_reg)) else $error("per channel invert");
  AST_ADDR: assert property (!ctrl[1] && ctrl[3:2] == host_parallel
    |=> host_reg_addr_out == $past(addr_pins_in)) else $error("host address");
endmodule
bind liu_global_pin_control liu_pin_sva i_sva (
  .core_clk_in(core_clk_in),
  .sys_rst_in(sys_rst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .pready_out(pready_out),
  .output_enable_in(output_enable_in),
  .edge_polarity_select_in(edge_polarity_select_in),
  .rx_external_term_out(rx_external_term_out),
  .serial_out_falling_edge_out(serial_out_falling_edge_out),
  .addr_pins_in(addr_pins_in),
  .host_reg_addr_out(host_reg_addr_out),
  .paddr_in(paddr_in),
  .tx_line_tip_oe_out(tx_line_tip_oe_out),
  .tx_line_ring_oe_out(tx_line_ring_oe_out),
  .rxclk_invert_out(rxclk_invert_out),
  .rx_line_tip_term_en_out(rx_line_tip_term_en_out),
  .monitor_rx_route_out(monitor_rx_route_out),
  .monitor_tx_route_out(monitor_tx_route_out),
  .pwdata_in(pwdata_in)
);
`default_nettype wire

// ===== verification/liu_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module liu_far_side (
  input wire logic ser_in,
  input wire logic [4:0] want_in,
  output logic [4:0] pins_out
);
  // board grounds the pins outside parallel host mode
  assign pins_out = ser_in ? 5'h00 : want_in;
endmodule
`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import liu_pin_pkg::*;
  logic core_clk_in = 0, sys_rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic output_enable_in = 0, edge_polarity_select_in = 0, serial_host_out_data_in = 0;
  logic e, pready_out, pslverr_out, rx_external_term_out, serial_out_falling_edge_out;
  logic serial_host_out_data_out;
  logic [7:0] paddr_in = 0, tx_line_tip_oe_out, tx_line_ring_oe_out, rxclk_invert_out;
  logic [7:0] rx_line_tip_term_en_out, monitor_rx_route_out, monitor_tx_route_out;
  logic [31:0] pwdata_in = 0, prdata_out, rd, r, v;
  logic [4:0] want = 0, la = 0, addr_pins_in, host_reg_addr_out;
  logic host_ser = 0;
  int failures = 0, n_checks = 0, seed = 32'h9165980f;
  always #2 core_clk_in = ~core_clk_in;
  liu_global_pin_control i_dut (.*);
  liu_far_side i_far (.ser_in(host_ser), .want_in(want), .pins_out(addr_pins_in));
  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, x);
    n_checks++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k = 0;
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    @(posedge core_clk_in) penable_in <= 1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1 && ++k < 20);
    rd = prdata_out;
    e = pslverr_out;
    {psel_in, penable_in} <= 2'h0;
    failures += k == 20;
    if (k == 20) finish_test;
    @(posedge core_clk_in);
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    sys_rst_in <= 0;
    @(posedge core_clk_in);
    apb(0, ctrl_offset, 0);
    chk("ctrl", rd, ctrl_reset);
    apb(0, 8'h10, 0);
    chk("err", e, 1);
    v = $random(seed) & 32'hFF;
    apb(1, rxclk_inv_offset, v);
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      apb(1, ctrl_offset, {i[4], r[8]});
      want <= {r[4], i[3:0]};
      output_enable_in <= r[5];
      edge_polarity_select_in <= r[6];
      serial_host_out_data_in <= r[7];
      repeat (2) @(posedge core_clk_in);
      chk("tip", tx_line_tip_oe_out, {8{r[5]}});
      chk("ring", tx_line_ring_oe_out, {8{r[5]}});
      chk("inv", rxclk_invert_out, r[6] ? 8'hFF : v);
      chk("edge", serial_out_falling_edge_out, r[6]);
      chk("sdo", serial_host_out_data_out, r[7]);
      if (i[4]) begin
        chk("term", rx_line_tip_term_en_out,
            r[4] || r[8] && !r[5] ? 0 : 8'hFF);
        chk("ext", rx_external_term_out, r[4]);
        chk("mrx", monitor_rx_route_out, i[3:0] inside {[1:7]} ? 32'h1 << i[3:0] : 0);
        chk("mtx", monitor_tx_route_out, i[3:0] > 8 ? 32'h1 << (i[3:0] - 8) : 0);
      end else begin
        la = {r[4], i[3:0]};
        chk("addr", host_reg_addr_out, la);
      end
    end
    apb(0, host_addr_offset, 0);
    chk("hreg", rd, la);
    host_ser <= 1;
    for (int m = 1; m < 3; m++) begin
      apb(1, ctrl_offset, m << 2);
      want <= 5'h1F;
      repeat (2) @(posedge core_clk_in);
      chk("hold", host_reg_addr_out, la);
    end
    apb(0, status_offset, 0);
    chk("status", {rd[7:4], rd[1:0]}, {4'h0, edge_polarity_select_in, output_enable_in});
    finish_test;
  end
endmodule
`default_nettype wire
